// ---- verilog/pls_consts.svh ----
/*
 Timing counts and fixed values for the PFC link start-up sequencer.
 Assumes a 200 MHz system clock; counts derive from times in microseconds.
*/
`ifndef PLS_CONSTS_SVH
`define PLS_CONSTS_SVH

`define PLS_CLK_MHZ         200
`define PLS_STATE_SET_US    48000
`define PLS_PFC_START_US    380000
`define PLS_NB_WIDTH_US     6000
`define PLS_BN_WIDTH_US     500
`define PLS_STOP_WIDTH_US   250
`define PLS_PULSE_GAP_US    4000
`define PLS_AC_LOSS_US      56000
`define PLS_XD_ON_US        1500
`define PLS_XD_OFF_US       500
`define PLS_US_TO_CYC(t)    ((t) * `PLS_CLK_MHZ)

`endif

// ---- verilog/pls_pkg.sv ----
/*
 Types shared by the PFC link start-up sequencer.
 Assumes the constants header is compiled alongside.
*/
`default_nettype none

package pls_pkg;
	typedef enum logic [1:0] {
		PLS_LVL_LOW,
		PLS_LVL_MID,
		PLS_LVL_HIGH
	} pls_level_t;

	typedef struct packed {
		logic charge_stop;
		logic run_start;
		logic charge_restart;
		logic line_100v;
		logic ac_present;
		logic want_burst;
		logic pfc_stop_req;
	} pls_sense_t;

	typedef struct packed {
		logic pfc_switch_en;
		logic llc_switch_en;
		logic hv_charge_en;
		logic xcap_discharge;
	} pls_drive_t;
endpackage

`default_nettype wire

// ---- verilog/pls_pulse_encoder.sv ----
/*
 Pulse-train encoder for mode commands sent to the PFC controller.
 Assumes the start strobe is a one-cycle pulse and sense inputs are synchronised.
*/
`include "pls_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pls_pulse_encoder #(
	parameter int unsigned NB_CYC   = `PLS_US_TO_CYC(`PLS_NB_WIDTH_US),
	parameter int unsigned BN_CYC   = `PLS_US_TO_CYC(`PLS_BN_WIDTH_US),
	parameter int unsigned STOP_CYC = `PLS_US_TO_CYC(`PLS_STOP_WIDTH_US),
	parameter int unsigned GAP_CYC  = `PLS_US_TO_CYC(`PLS_PULSE_GAP_US)
) (
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	input  wire logic              start,
	input  wire logic              to_burst,
	input  wire logic              line_100v,
	input  wire logic              stop_req,
	output logic                   busy,
	output pls_pkg::pls_level_t    level
);
	import pls_pkg::*;

	typedef enum logic [1:0] {PE_IDLE, PE_PULSE, PE_GAP, PE_STOP} pe_state_t;

	pe_state_t           state_reg, state_next;
	logic [31:0]         cnt_reg, cnt_next;
	logic                second_reg, second_next;
	logic [31:0]         width_reg, width_next;
	pls_level_t          level_reg, level_next;

	always_comb begin
		state_next  = state_reg;
		cnt_next    = cnt_reg + 32'h1;
		second_next = second_reg;
		width_next  = width_reg;
		level_next  = level_reg;
		unique case (state_reg)
			PE_IDLE: begin
				cnt_next   = 32'h0;
				level_next = PLS_LVL_LOW;
				if (stop_req) begin
					state_next = PE_STOP;
					level_next = PLS_LVL_HIGH;
				end else if (start) begin
					state_next  = PE_PULSE;
					level_next  = PLS_LVL_MID;
					width_next  = to_burst ? NB_CYC : BN_CYC;
					second_next = line_100v;
				end
			end
			PE_PULSE: if (cnt_reg >= width_reg - 32'h1) begin
				cnt_next   = 32'h0;
				level_next = PLS_LVL_LOW;
				state_next = second_reg ? PE_GAP : PE_IDLE;
			end
			PE_GAP: if (cnt_reg >= GAP_CYC - 32'h1) begin
				cnt_next    = 32'h0;
				second_next = 1'b0;
				level_next  = PLS_LVL_MID;
				state_next  = PE_PULSE;
			end
			PE_STOP: begin
				// Square train: high for one width, low for the next, while stop holds
				if (cnt_reg >= STOP_CYC - 32'h1) begin
					cnt_next   = 32'h0;
					level_next = (level_reg == PLS_LVL_HIGH) ? PLS_LVL_LOW : PLS_LVL_HIGH;
					if (!stop_req && level_reg == PLS_LVL_HIGH) begin
						state_next = PE_IDLE;
						level_next = PLS_LVL_LOW;
					end
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg  <= PE_IDLE;
			cnt_reg    <= 32'h0;
			second_reg <= 1'b0;
			width_reg  <= 32'h0;
			level_reg  <= PLS_LVL_LOW;
		end else begin
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			second_reg <= second_next;
			width_reg  <= width_next;
			level_reg  <= level_next;
		end
	end

	assign busy  = (state_reg != PE_IDLE);
	assign level = level_reg;

	mid_width_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(state_reg == PE_IDLE && start && !stop_req && !to_burst)
		|=> (level == PLS_LVL_MID) [*8])
		else $error("burst-to-normal pulse ended too early");

	stop_high_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(state_reg == PE_IDLE && stop_req) |=> level == PLS_LVL_HIGH)
		else $error("stop train did not start high");
endmodule // pls_pulse_encoder

`default_nettype wire

// ---- verilog/pls_sequencer.sv ----
/*
 PFC link start-up sequencer: start-up phases, PFC mode commands, X-cap discharge.
 Assumes comparator inputs are raw levels and the strap is stable at start-up.
*/
`include "pls_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - In auto standby, PFC mode is commanded only by pulses on the mode pin.
// - Burst or normal decision changes trigger the matching command.
// - Normal-to-burst: mid-level 6ms pulses, two for 100V line, one for 200V.
// - Burst-to-normal: mid-level 0.5ms pulses, two for 100V, one for 200V.
// - PFC stop: continuous high-level 0.25ms pulses while stop is wanted.
// - On reaching charge-stop level, state setting runs at most 48ms.
// - Then, in auto standby only, a 380ms PFC start-up period allows only PFC switching.
// - In that period, run-start level enables PFC with LLC held off.
// - In that period, charge-restart level halts PFC; cycle repeats.
// - Period expiry stops PFC and enters combined operation.
// - In combined phase, run-start level enables PFC and LLC together.
// - High-voltage charging stays off while the auxiliary winding supplies power.
// - After AC loss, wait 56ms before X-cap discharge.
// - Discharge pulses on 1.5ms, off 0.5ms while active.
// - AC restoration ends the discharge at once.
// - Mode pin drives commands only if auto standby chosen at start-up.
module pls_sequencer #(
	parameter int unsigned SET_CYC   = `PLS_US_TO_CYC(`PLS_STATE_SET_US),
	parameter int unsigned PRE_CYC   = `PLS_US_TO_CYC(`PLS_PFC_START_US),
	parameter int unsigned LOSS_CYC  = `PLS_US_TO_CYC(`PLS_AC_LOSS_US),
	parameter int unsigned XON_CYC   = `PLS_US_TO_CYC(`PLS_XD_ON_US),
	parameter int unsigned XOFF_CYC  = `PLS_US_TO_CYC(`PLS_XD_OFF_US),
	parameter int unsigned NB_CYC    = `PLS_US_TO_CYC(`PLS_NB_WIDTH_US),
	parameter int unsigned BN_CYC    = `PLS_US_TO_CYC(`PLS_BN_WIDTH_US),
	parameter int unsigned STOP_CYC  = `PLS_US_TO_CYC(`PLS_STOP_WIDTH_US),
	parameter int unsigned GAP_CYC   = `PLS_US_TO_CYC(`PLS_PULSE_GAP_US)
) (
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	input  wire pls_pkg::pls_sense_t sense_in,
	input  wire logic              auto_standby_strap,
	input  wire logic              mode_signal_pin_i,
	output pls_pkg::pls_level_t    mode_signal_pin_level,
	output logic                   mode_signal_pin_oe,
	output logic                   ext_standby_req,
	output pls_pkg::pls_drive_t    drive
);
	import pls_pkg::*;

	typedef enum logic [2:0] {
		SQ_CHARGE, SQ_SETTING, SQ_PRE_WAIT, SQ_PRE_RUN, SQ_JOINT_WAIT, SQ_RUN
	} sq_state_t;
	typedef enum logic [1:0] {XD_IDLE, XD_WAIT, XD_ON, XD_OFF} xd_state_t;

	pls_sense_t  sync1_reg, sync2_reg;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= sense_in;
			sync2_reg <= sync1_reg;
		end
	end

	sq_state_t   sq_reg, sq_next;
	logic [31:0] sq_cnt_reg, sq_cnt_next;
	logic [31:0] pre_cnt_reg, pre_cnt_next;
	logic        auto_reg, auto_next;
	logic        burst_reg, burst_next;
	logic        cmd_start;
	logic        enc_busy;
	pls_level_t  enc_level;

	function automatic logic expired(input logic [31:0] cnt, input int unsigned lim);
		expired = (cnt >= lim - 32'h1);
	endfunction

	always_comb begin
		sq_next      = sq_reg;
		sq_cnt_next  = sq_cnt_reg + 32'h1;
		pre_cnt_next = pre_cnt_reg;
		auto_next    = auto_reg;
		unique case (sq_reg)
			SQ_CHARGE: begin
				sq_cnt_next = 32'h0;
				if (sync2_reg.charge_stop) begin
					sq_next   = SQ_SETTING;
					auto_next = auto_standby_strap;
				end
			end
			SQ_SETTING: if (expired(sq_cnt_reg, SET_CYC)) begin
				sq_cnt_next  = 32'h0;
				pre_cnt_next = 32'h0;
				sq_next      = auto_reg ? SQ_PRE_WAIT : SQ_JOINT_WAIT;
			end
			SQ_PRE_WAIT, SQ_PRE_RUN: begin
				pre_cnt_next = pre_cnt_reg + 32'h1;
				if (expired(pre_cnt_reg, PRE_CYC))
					sq_next = SQ_JOINT_WAIT;
				else if (sq_reg == SQ_PRE_WAIT && sync2_reg.run_start)
					sq_next = SQ_PRE_RUN;
				else if (sq_reg == SQ_PRE_RUN && sync2_reg.charge_restart)
					sq_next = SQ_PRE_WAIT;
			end
			SQ_JOINT_WAIT: if (sync2_reg.run_start)
				sq_next = SQ_RUN;
			SQ_RUN: sq_cnt_next = 32'h0;
		endcase
	end

	// Decision tracking only once joint switching runs; a pending stop holds the change
	// back, since stop wins in the encoder and the decision would otherwise be lost
	always_comb begin
		burst_next = burst_reg;
		cmd_start  = 1'b0;
		if (sq_reg == SQ_RUN && auto_reg && !sync2_reg.pfc_stop_req
			&& sync2_reg.want_burst != burst_reg) begin
			cmd_start  = !enc_busy;
			burst_next = enc_busy ? burst_reg : sync2_reg.want_burst;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sq_reg      <= SQ_CHARGE;
			sq_cnt_reg  <= 32'h0;
			pre_cnt_reg <= 32'h0;
			auto_reg    <= 1'b0;
			burst_reg   <= 1'b0;
		end else begin
			sq_reg      <= sq_next;
			sq_cnt_reg  <= sq_cnt_next;
			pre_cnt_reg <= pre_cnt_next;
			auto_reg    <= auto_next;
			burst_reg   <= burst_next;
		end
	end

	pls_pulse_encoder #(
		.NB_CYC   (NB_CYC),
		.BN_CYC   (BN_CYC),
		.STOP_CYC (STOP_CYC),
		.GAP_CYC  (GAP_CYC)
	) u_enc (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.start     (cmd_start),
		.to_burst  (burst_next),
		.line_100v (sync2_reg.line_100v),
		.stop_req  (auto_reg && sq_reg == SQ_RUN && sync2_reg.pfc_stop_req),
		.busy      (enc_busy),
		.level     (enc_level)
	);

	// Pin drives only in auto standby; otherwise it is the external standby input
	assign mode_signal_pin_oe    = auto_reg;
	assign mode_signal_pin_level = auto_reg ? enc_level : PLS_LVL_LOW;
	assign ext_standby_req       = !auto_reg && sq_reg == SQ_RUN && mode_signal_pin_i;

	xd_state_t   xd_reg, xd_next;
	logic [31:0] xd_cnt_reg, xd_cnt_next;
	always_comb begin
		xd_next     = xd_reg;
		xd_cnt_next = xd_cnt_reg + 32'h1;
		if (sync2_reg.ac_present) begin
			xd_next     = XD_IDLE;
			xd_cnt_next = 32'h0;
		end else begin
			unique case (xd_reg)
				XD_IDLE: begin
					xd_next     = XD_WAIT;
					xd_cnt_next = 32'h0;
				end
				XD_WAIT: if (expired(xd_cnt_reg, LOSS_CYC)) begin
					xd_next     = XD_ON;
					xd_cnt_next = 32'h0;
				end
				XD_ON: if (expired(xd_cnt_reg, XON_CYC)) begin
					xd_next     = XD_OFF;
					xd_cnt_next = 32'h0;
				end
				XD_OFF: if (expired(xd_cnt_reg, XOFF_CYC)) begin
					xd_next     = XD_ON;
					xd_cnt_next = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			xd_reg     <= XD_IDLE;
			xd_cnt_reg <= 32'h0;
		end else begin
			xd_reg     <= xd_next;
			xd_cnt_reg <= xd_cnt_next;
		end
	end

	always_comb begin
		drive.pfc_switch_en  = (sq_reg == SQ_PRE_RUN) || (sq_reg == SQ_RUN);
		drive.llc_switch_en  = (sq_reg == SQ_RUN);
		// Once running the auxiliary winding carries the supply
		drive.hv_charge_en   = (sq_reg != SQ_RUN);
		drive.xcap_discharge = (xd_reg == XD_ON);
	end

	llc_pre_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(sq_reg == SQ_PRE_RUN) |-> (drive.pfc_switch_en && !drive.llc_switch_en))
		else $error("LLC switching during PFC start-up");

	set_exit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(sq_reg == SQ_SETTING) |-> (sq_cnt_reg < SET_CYC))
		else $error("state setting overran");

	pre_end_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(sq_reg inside {SQ_PRE_WAIT, SQ_PRE_RUN} && pre_cnt_reg == PRE_CYC - 1)
		|=> (sq_reg == SQ_JOINT_WAIT && !drive.pfc_switch_en))
		else $error("PFC start-up period did not end");

	xd_restore_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		sync2_reg.ac_present |=> !drive.xcap_discharge)
		else $error("discharge continued after AC restored");

	xd_delay_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(xd_reg == XD_WAIT) |-> !drive.xcap_discharge [*8])
		else $error("discharge began without delay");

	hv_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		drive.llc_switch_en |-> !drive.hv_charge_en)
		else $error("charging path on in normal operation");

	pin_mode_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		!auto_reg |-> (!mode_signal_pin_oe && !enc_busy))
		else $error("mode pin driven outside auto standby");

	cmd_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		cmd_start |-> (auto_reg && sq_reg == SQ_RUN && !enc_busy) ##1 enc_busy)
		else $error("command issued outside joint run");
endmodule // pls_sequencer

`default_nettype wire

// ---- bench/pls_pfc_model.sv ----
/*
 Behavioural PFC controller that decodes mode pulses from the sequencer.
 Assumes it shares the sequencer clock; widths and gaps are counted in cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module pls_pfc_model #(
	parameter int unsigned BURST_MIN = 18
) (
	input  wire logic                sys_clk,
	input  wire pls_pkg::pls_level_t level,
	input  wire logic                oe,
	output int unsigned              pulse_cnt,
	output int unsigned              width,
	output int unsigned              gap,
	output int unsigned              quiet,
	output pls_pkg::pls_level_t      lvl,
	output int unsigned              mode
);
	import pls_pkg::*;
	pls_level_t  seen;
	pls_level_t  prev_reg = PLS_LVL_LOW;
	int unsigned run_len = 0;
	int unsigned count_reg = 0;
	int unsigned mode_reg = 0;

	// An undriven pin reads low through the receiver's pull-down
	assign seen = oe ? level : PLS_LVL_LOW;
	assign quiet = (seen == PLS_LVL_LOW && prev_reg == PLS_LVL_LOW) ? run_len : 0;
	assign pulse_cnt = count_reg;
	assign mode = mode_reg;

	always @(posedge sys_clk) begin
		prev_reg <= seen;
		if (seen == prev_reg) begin
			run_len <= run_len + 1;
		end else begin
			run_len <= 1;
			if (prev_reg != PLS_LVL_LOW) begin
				count_reg <= count_reg + 1;
				width <= run_len;
				lvl <= prev_reg;
				// Level picks stop, width picks burst or normal
				mode_reg <= (prev_reg == PLS_LVL_HIGH) ? 2 : ((run_len >= BURST_MIN) ? 1 : 0);
			end else begin
				gap <= run_len;
			end
		end
	end
endmodule // pls_pfc_model

`default_nettype wire

// ---- bench/testbench.sv ----
/*
 Self-checking bench for the PFC link start-up sequencer.
 Assumes shortened timing parameters; all expectations derive from them.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import pls_pkg::*;
	localparam int unsigned SET_CYC = 20, PRE_CYC = 100, LOSS_CYC = 40, XON_CYC = 30;
	localparam int unsigned XOFF_CYC = 10, NB_CYC = 24, BN_CYC = 12, STOP_CYC = 10;
	localparam int unsigned GAP_CYC = 16;
	localparam int          PFC = 3, LLC = 2, XD = 0;
	logic        sys_clk, rstn, strap, pin_i, pin_oe, ext_req;
	pls_sense_t  sense;
	pls_level_t  pin_level, lvl;
	pls_drive_t  drive;
	logic [3:0]  dv;
	int unsigned errors = 0, checks = 0, cyc_cnt = 0, t, n0;
	int unsigned pulse_cnt, width, gap, quiet, mode;

	assign dv = drive;

	pls_sequencer #(.SET_CYC(SET_CYC), .PRE_CYC(PRE_CYC), .LOSS_CYC(LOSS_CYC),
		.XON_CYC(XON_CYC), .XOFF_CYC(XOFF_CYC), .NB_CYC(NB_CYC), .BN_CYC(BN_CYC),
		.STOP_CYC(STOP_CYC), .GAP_CYC(GAP_CYC)) dut (.sys_clk(sys_clk), .rstn(rstn),
		.sense_in(sense), .auto_standby_strap(strap), .mode_signal_pin_i(pin_i),
		.mode_signal_pin_level(pin_level), .mode_signal_pin_oe(pin_oe),
		.ext_standby_req(ext_req), .drive(drive));

	pls_pfc_model #(.BURST_MIN((NB_CYC + BN_CYC) / 2)) pfc (.sys_clk(sys_clk),
		.level(pin_level), .oe(pin_oe), .pulse_cnt(pulse_cnt), .width(width), .gap(gap),
		.quiet(quiet), .lvl(lvl), .mode(mode));

	task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %0h expected %0h", $time, m, got, exp);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wt(int i, logic v, int lim, output int unsigned n);
		n = 0;
		while (dv[i] !== v && n < lim) begin
			cyc(1);
			n++;
		end
	endtask

	// Returns once a new pulse has come and the line has rested longer than a gap
	task automatic settle;
		t = 0;
		while ((pulse_cnt == n0 || quiet <= GAP_CYC + 2) && t < 400) begin
			cyc(1);
			t++;
		end
	endtask

	task automatic do_reset;
		sense = '0;
		sense.ac_present = 1;
		pin_i = 0;
		rstn = 0;
		cyc(8);
		rstn = 1;
	endtask

	task automatic test_auto_startup;
		chk(dv, 4'h2, "reset drive");
		chk(pin_oe, 0, "reset pin enable");
		sense.charge_stop = 1;
		sense.run_start = 1;
		cyc(SET_CYC / 2);
		chk(dv[PFC], 0, "switching in state setting");
		wt(PFC, 1, SET_CYC + 10, t);
		chk(t <= SET_CYC / 2 + 8, 1, "state setting too long");
		chk(dv[LLC], 0, "llc in pfc start-up");
		sense.run_start = 0;
		sense.charge_restart = 1;
		cyc(5);
		chk(dv[PFC], 0, "pfc halt at restart level");
		sense.charge_restart = 0;
		sense.run_start = 1;
		cyc(5);
		chk({dv[PFC], dv[LLC]}, 2'b10, "pfc resumes alone");
		// Supply sits below run-start at period end, so the joint phase must wait
		sense.run_start = 0;
		wt(PFC, 0, PRE_CYC + 10, t);
		chk({dv[PFC], dv[LLC]}, 2'b00, "start-up period end");
		cyc(4);
		chk({dv[PFC], dv[LLC]}, 2'b00, "joint waits for run-start");
		sense.run_start = 1;
		wt(LLC, 1, 10, t);
		chk({dv[PFC], dv[LLC]}, 2'b11, "joint switching");
		cyc(2);
		chk(dv[1], 0, "hv charging in run");
		chk(pin_oe, 1, "pin enable in auto");
	endtask

	task automatic cmd(logic burst, logic l100);
		n0 = pulse_cnt;
		sense.line_100v = l100;
		sense.want_burst = burst;
		settle;
		chk(pulse_cnt - n0, l100 ? 2 : 1, "pulse count");
		chk(width, burst ? NB_CYC : BN_CYC, "pulse width");
		chk(lvl, PLS_LVL_MID, "pulse level");
		chk(mode, burst, "decoded mode");
		if (l100) begin
			chk(gap, GAP_CYC, "pulse gap");
		end
	endtask

	task automatic test_commands;
		for (int k = 0; k < 4; k++) begin
			cmd(k % 2 == 0, k < 2);
		end
	endtask

	task automatic test_stop;
		n0 = pulse_cnt;
		sense.pfc_stop_req = 1;
		t = 0;
		while (pulse_cnt - n0 < 3 && t < 200) begin
			cyc(1);
			t++;
		end
		chk(lvl, PLS_LVL_HIGH, "stop level");
		chk(width, STOP_CYC, "stop width");
		chk(gap, STOP_CYC, "stop spacing");
		chk(mode, 2, "decoded stop");
		sense.pfc_stop_req = 0;
		settle;
		chk(pin_level, PLS_LVL_LOW, "stop train ends");
	endtask

	task automatic test_xcap;
		sense.ac_present = 0;
		wt(XD, 1, LOSS_CYC + 10, t);
		chk(t >= LOSS_CYC && t <= LOSS_CYC + 4, 1, "discharge delay");
		wt(XD, 0, 100, t);
		chk(t, XON_CYC, "discharge on time");
		wt(XD, 1, 100, t);
		chk(t, XOFF_CYC, "discharge off time");
		cyc(5);
		sense.ac_present = 1;
		cyc(6);
		chk(dv[XD], 0, "discharge ends");
		wt(XD, 1, XON_CYC + XOFF_CYC, t);
		chk(dv[XD], 0, "discharge stays off");
	endtask

	task automatic test_ext_standby;
		strap = 0;
		do_reset;
		sense.charge_stop = 1;
		sense.run_start = 1;
		wt(LLC, 1, SET_CYC + 10, t);
		chk(t <= SET_CYC + 8, 1, "no pre period without auto");
		chk(dv[PFC], 1, "joint start");
		pin_i = 1;
		cyc(1);
		chk(ext_req, 1, "standby input");
		chk(pin_oe, 0, "pin not driven");
		pin_i = 0;
		cyc(1);
		chk(ext_req, 0, "standby input released");
		n0 = pulse_cnt;
		sense.want_burst = 1;
		cyc(60);
		chk(pulse_cnt - n0, 0, "no pulses without auto");
	endtask

	task automatic test_done;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		sys_clk = 0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// Run takes under 3000 cycles; the ceiling leaves wide margin
	always @(posedge sys_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			errors++;
			test_done;
		end
	end

	initial begin
		strap = 1;
		do_reset;
		test_auto_startup;
		test_commands;
		test_stop;
		test_xcap;
		test_ext_standby;
		test_done;
	end
endmodule // testbench

`default_nettype wire
